// [logic/cci_command_interpreter.v]
// Command interpreter with device numbering and extended-address setup
`include "cci_map.vh"

////////////////////////////////////////////////////////////////////////////////
module cci_command_interpreter #(
	parameter [47:0] MAKER_LOW   = 48'h303030303030, // arbitrary
	parameter [47:0] MAKER_HIGH  = 48'h303030303030, // arbitrary
	parameter [47:0] MODEL_LOW   = 48'h303030303030, // arbitrary
	parameter [47:0] MODEL_HIGH  = 48'h303030303030, // arbitrary
	parameter [47:0] FW_REVS     = 48'hFFFFFFFFFF00, // arbitrary
	parameter integer ARM_CYCLES   = `CCI_ARM_WINDOW_MS * (`CCI_CLK_HZ / 1000),
	parameter integer SET_CYCLES   = `CCI_SET_WINDOW_MS * (`CCI_CLK_HZ / 1000),
	parameter integer BLINK_CYCLES = `CCI_BLINK_HALF_MS * (`CCI_CLK_HZ / 1000)
) (
	// Clock and reset
	input  wire        i_sys_clk,
	input  wire        i_resetn,
	// Operator inputs, switch high = OFF
	input  wire [2:0]  i_dip,
	input  wire        i_remote_off,
	// Request from CAN controller
	input  wire        i_req_valid,
	input  wire [28:0] i_req_id,
	input  wire [3:0]  i_req_len,
	input  wire [63:0] i_req_data,
	// Response to CAN controller
	output reg         o_rsp_valid,
	output reg  [28:0] o_rsp_id,
	output reg  [3:0]  o_rsp_len,
	output reg  [63:0] o_rsp_data,
	// Measurements and status from the power stage
	input  wire [15:0] i_fault_summary,
	input  wire [15:0] i_ac_voltage,
	input  wire [15:0] i_dc_voltage,
	input  wire [15:0] i_dc_current,
	input  wire [15:0] i_temperature,
	input  wire [15:0] i_fan1_speed,
	input  wire [15:0] i_fan2_speed,
	input  wire [15:0] i_system_state,
	// Settings to the power stage
	output wire        o_output_on,
	output wire        o_dc_to_ac,
	output reg  [15:0] o_charge_v_set,
	output reg  [15:0] o_charge_i_set,
	output reg  [15:0] o_discharge_v_set,
	output reg  [15:0] o_discharge_i_set,
	output reg  [15:0] o_setup_word,
	output reg  [15:0] o_two_way_setup,
	output reg         o_nv_store,
	// Addressing and indicator
	output wire [5:0]  o_device_number,
	output reg         o_led_green,
	output wire        o_cfg_busy
);

	localparam [2:0] S_START  = 3'h0;
	localparam [2:0] S_WATCH  = 3'h1;
	localparam [2:0] S_SAW_ON = 3'h2;
	localparam [2:0] S_BLINKA = 3'h3;
	localparam [2:0] S_SETTLE = 3'h4;
	localparam [2:0] S_BLINKB = 3'h5;
	localparam [2:0] S_DONE   = 3'h6;

	reg         rst_meta;
	reg         rst_sync;
	reg  [2:0]  state;
	reg  [31:0] timer;
	reg  [3:0]  halves;
	reg  [2:0]  ext_bits;
	reg  [7:0]  onoff;
	reg  [7:0]  direction;
	reg  [23:0] location;
	reg  [47:0] build_date;
	reg  [47:0] serial_low;
	reg  [47:0] serial_high;
	reg         cmd_known;
	reg         cmd_rw;
	reg  [3:0]  cmd_bytes;
	reg  [47:0] rd_val;

	wire [15:0] code  = i_req_data[15:0];
	wire [47:0] wdat  = i_req_data[63:16];
	wire [7:0]  dev8  = {2'h0, o_device_number};
	wire        to_us = (i_req_id[28:8] == `CCI_ID_REQ_BASE) &&
	                    ((i_req_id[7:0] == dev8) || (i_req_id[7:0] == `CCI_ID_BROADCAST));
	wire        is_rd = i_req_valid && to_us && cmd_known && (i_req_len == 4'h2);
	wire        is_wr = i_req_valid && to_us && cmd_known && cmd_rw &&
	                    (i_req_len == cmd_bytes + 4'h2);
	wire        half_done = (timer >= BLINK_CYCLES - 1);

	////////////////////////////////////////////////////////////////////////////
	// Reset release
	always @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Addressing
	// number from switches
	assign o_device_number = {ext_bits, i_dip};
	assign o_cfg_busy      = (state != S_DONE);
	assign o_output_on     = (onoff == `CCI_VAL_ON) && !o_cfg_busy && !i_remote_off;
	assign o_dc_to_ac      = (direction == `CCI_VAL_DC_TO_AC);

	////////////////////////////////////////////////////////////////////////////
	// Extended-address setup sequence
	always @(posedge i_sys_clk or negedge rst_sync) begin
		if (!rst_sync) begin
			state       <= S_START;
			timer       <= 32'h0;
			halves      <= 4'h0;
			ext_bits    <= 3'h0;
			o_led_green <= 1'b0;
		end else begin
			case (state)
				S_START: begin
					timer <= 32'h0;
					if ((i_dip == 3'h7) && i_remote_off)
						state <= S_WATCH;
					else
						state <= S_DONE;
				end
				S_WATCH: begin
					timer <= timer + 32'h1;
					if (timer >= ARM_CYCLES - 1)
						state <= S_DONE;
					else if (!i_dip[2])
						state <= S_SAW_ON;
				end
				S_SAW_ON: begin
					timer <= timer + 32'h1;
					if (timer >= ARM_CYCLES - 1) begin
						state <= S_DONE;
					end else if (i_dip[2]) begin
						state       <= S_BLINKA;
						timer       <= 32'h0;
						halves      <= 4'h0;
						o_led_green <= 1'b1;
					end
				end
				S_BLINKA, S_BLINKB: begin
					if (half_done) begin
						timer  <= 32'h0;
						halves <= halves + 4'h1;
						if (halves == `CCI_BLINK_HALVES - 1) begin
							o_led_green <= 1'b0;
							state       <= (state == S_BLINKA) ? S_SETTLE : S_DONE;
						end else begin
							o_led_green <= ~o_led_green;
						end
					end else begin
						timer <= timer + 32'h1;
					end
				end
				S_SETTLE: begin
					if (timer >= SET_CYCLES - 1) begin
						ext_bits    <= i_dip;
						state       <= S_BLINKB;
						timer       <= 32'h0;
						halves      <= 4'h0;
						o_led_green <= 1'b1;
					end else begin
						timer <= timer + 32'h1;
					end
				end
				S_DONE: begin
					timer <= 32'h0;
				end
				default: begin
					state <= S_DONE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Command table
	// raw values pass unscaled; factors apply outside
	always @* begin
		cmd_known = 1'b1;
		cmd_rw    = 1'b0;
		cmd_bytes = 4'h2;
		rd_val    = 48'h0;
		case (code)
			`CCI_CMD_OUTPUT_ON_OFF: begin
				cmd_rw    = 1'b1;
				cmd_bytes = 4'h1;
				rd_val    = {40'h0, onoff};
			end
			`CCI_CMD_CHARGE_V_SET: begin
				cmd_rw = 1'b1;
				rd_val = {32'h0, o_charge_v_set};
			end
			`CCI_CMD_CHARGE_I_SET: begin
				cmd_rw = 1'b1;
				rd_val = {32'h0, o_charge_i_set};
			end
			`CCI_CMD_FAULT_SUMMARY: rd_val = {32'h0, i_fault_summary};
			`CCI_CMD_AC_V_READING:  rd_val = {32'h0, i_ac_voltage};
			`CCI_CMD_DC_V_READING:  rd_val = {32'h0, i_dc_voltage};
			`CCI_CMD_DC_I_READING:  rd_val = {32'h0, i_dc_current};
			`CCI_CMD_TEMP_READING:  rd_val = {32'h0, i_temperature};
			`CCI_CMD_FAN1_SPEED:    rd_val = {32'h0, i_fan1_speed};
			`CCI_CMD_FAN2_SPEED:    rd_val = {32'h0, i_fan2_speed};
			`CCI_CMD_MAKER_LOW: begin
				cmd_bytes = 4'h6;
				rd_val    = MAKER_LOW;
			end
			`CCI_CMD_MAKER_HIGH: begin
				cmd_bytes = 4'h6;
				rd_val    = MAKER_HIGH;
			end
			`CCI_CMD_MODEL_LOW: begin
				cmd_bytes = 4'h6;
				rd_val    = MODEL_LOW;
			end
			`CCI_CMD_MODEL_HIGH: begin
				cmd_bytes = 4'h6;
				rd_val    = MODEL_HIGH;
			end
			`CCI_CMD_FW_REVS: begin
				cmd_bytes = 4'h6;
				rd_val    = FW_REVS;
			end
			`CCI_CMD_LOCATION: begin
				cmd_rw    = 1'b1;
				cmd_bytes = 4'h3;
				rd_val    = {24'h0, location};
			end
			`CCI_CMD_BUILD_DATE: begin
				cmd_rw    = 1'b1;
				cmd_bytes = 4'h6;
				rd_val    = build_date;
			end
			`CCI_CMD_SERIAL_LOW: begin
				cmd_rw    = 1'b1;
				cmd_bytes = 4'h6;
				rd_val    = serial_low;
			end
			`CCI_CMD_SERIAL_HIGH: begin
				cmd_rw    = 1'b1;
				cmd_bytes = 4'h6;
				rd_val    = serial_high;
			end
			`CCI_CMD_SCALE_CODES:   rd_val = {32'h0, `CCI_SCALE_CODES_RESET};
			`CCI_CMD_SYSTEM_STATE:  rd_val = {32'h0, i_system_state};
			`CCI_CMD_SYSTEM_SETUP: begin
				cmd_rw = 1'b1;
				rd_val = {32'h0, o_setup_word};
			end
			`CCI_CMD_DIRECTION: begin
				cmd_rw    = 1'b1;
				cmd_bytes = 4'h1;
				rd_val    = {40'h0, direction};
			end
			`CCI_CMD_DISCHARGE_V_SET: begin
				cmd_rw = 1'b1;
				rd_val = {32'h0, o_discharge_v_set};
			end
			`CCI_CMD_DISCHARGE_I_SET: begin
				cmd_rw = 1'b1;
				rd_val = {32'h0, o_discharge_i_set};
			end
			`CCI_CMD_TWO_WAY_SETUP: begin
				cmd_rw = 1'b1;
				rd_val = {32'h0, o_two_way_setup};
			end
			default: cmd_known = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Stored settings
	always @(posedge i_sys_clk or negedge rst_sync) begin
		if (!rst_sync) begin
			onoff             <= 8'h00;
			direction         <= 8'h00;
			o_charge_v_set    <= 16'h0000;
			o_charge_i_set    <= 16'h0000;
			o_discharge_v_set <= 16'h0000;
			o_discharge_i_set <= 16'h0000;
			o_setup_word      <= `CCI_SETUP_RESET;
			o_two_way_setup   <= 16'h0000;
			location          <= 24'h000000;
			build_date        <= 48'h0;
			serial_low        <= 48'h0;
			serial_high       <= 48'h0;
			o_nv_store        <= 1'b0;
		end else begin
			o_nv_store <= 1'b0;
			// data follows the code, low byte first
			if (is_wr) begin
				case (code)
					`CCI_CMD_OUTPUT_ON_OFF:   onoff             <= wdat[7:0];
					`CCI_CMD_DIRECTION:       direction         <= wdat[7:0];
					`CCI_CMD_CHARGE_V_SET:    o_charge_v_set    <= wdat[15:0];
					`CCI_CMD_CHARGE_I_SET:    o_charge_i_set    <= wdat[15:0];
					`CCI_CMD_DISCHARGE_V_SET: o_discharge_v_set <= wdat[15:0];
					`CCI_CMD_DISCHARGE_I_SET: o_discharge_i_set <= wdat[15:0];
					`CCI_CMD_SYSTEM_SETUP:    o_setup_word      <= wdat[15:0];
					`CCI_CMD_TWO_WAY_SETUP:   o_two_way_setup   <= wdat[15:0];
					`CCI_CMD_LOCATION:        location          <= wdat[23:0];
					`CCI_CMD_BUILD_DATE:      build_date        <= wdat;
					`CCI_CMD_SERIAL_LOW:      serial_low        <= wdat;
					`CCI_CMD_SERIAL_HIGH:     serial_high       <= wdat;
					default:                  onoff             <= onoff;
				endcase
				// save unless disabled, only when set up
				if (((code == `CCI_CMD_CHARGE_V_SET) || (code == `CCI_CMD_CHARGE_I_SET) ||
				     (code == `CCI_CMD_DISCHARGE_V_SET) || (code == `CCI_CMD_DISCHARGE_I_SET)) &&
				    !o_setup_word[`CCI_SETUP_NVS_DISABLE_BIT] &&
				    o_setup_word[`CCI_SETUP_NVS_SETUP_BIT])
					o_nv_store <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Responses
	always @(posedge i_sys_clk or negedge rst_sync) begin
		if (!rst_sync) begin
			o_rsp_valid <= 1'b0;
			o_rsp_id    <= 29'h0;
			o_rsp_len   <= 4'h0;
			o_rsp_data  <= 64'h0;
		end else begin
			o_rsp_valid <= is_rd;
			if (is_rd) begin
				o_rsp_id   <= {`CCI_ID_RSP_BASE, dev8};
				o_rsp_len  <= cmd_bytes + 4'h2;
				// code first, data low byte first
				o_rsp_data <= {rd_val, code};
			end
		end
	end

endmodule // cci_command_interpreter

// [logic/cci_map.vh]
// Command codes, identifier bases, field positions and timing for the command interpreter
`ifndef CCI_MAP_VH
`define CCI_MAP_VH

// Command codes
`define CCI_CMD_OUTPUT_ON_OFF      16'h0000
`define CCI_CMD_CHARGE_V_SET       16'h0020
`define CCI_CMD_CHARGE_I_SET       16'h0030
`define CCI_CMD_FAULT_SUMMARY      16'h0040
`define CCI_CMD_AC_V_READING       16'h0050
`define CCI_CMD_DC_V_READING       16'h0060
`define CCI_CMD_DC_I_READING       16'h0061
`define CCI_CMD_TEMP_READING       16'h0062
`define CCI_CMD_FAN1_SPEED         16'h0070
`define CCI_CMD_FAN2_SPEED         16'h0071
`define CCI_CMD_MAKER_LOW          16'h0080
`define CCI_CMD_MAKER_HIGH         16'h0081
`define CCI_CMD_MODEL_LOW          16'h0082
`define CCI_CMD_MODEL_HIGH         16'h0083
`define CCI_CMD_FW_REVS            16'h0084
`define CCI_CMD_LOCATION           16'h0085
`define CCI_CMD_BUILD_DATE         16'h0086
`define CCI_CMD_SERIAL_LOW         16'h0087
`define CCI_CMD_SERIAL_HIGH        16'h0088
`define CCI_CMD_SCALE_CODES        16'h00C0
`define CCI_CMD_SYSTEM_STATE       16'h00C1
`define CCI_CMD_SYSTEM_SETUP       16'h00C2
`define CCI_CMD_DIRECTION          16'h0100
`define CCI_CMD_DISCHARGE_V_SET    16'h0120
`define CCI_CMD_DISCHARGE_I_SET    16'h0130
`define CCI_CMD_TWO_WAY_SETUP      16'h0140

// Extended identifiers: base in bits 28:8, device field in bits 7:0
`define CCI_ID_REQ_BASE            21'h000C03
`define CCI_ID_RSP_BASE            21'h000C02
`define CCI_ID_BROADCAST           8'hFF

// Byte values
`define CCI_VAL_ON                 8'h01
`define CCI_VAL_DC_TO_AC           8'h01

// Scale codes: VOUT 0.01, IOUT 0.01, VIN 0.1, FAN 1
`define CCI_SCALE_CODES_RESET      16'h7655

// Setup word bits
`define CCI_SETUP_NVS_DISABLE_BIT  0
`define CCI_SETUP_NVS_SETUP_BIT    1
`define CCI_SETUP_RESET            16'h0000

// Timing
`define CCI_CLK_HZ                 10000000
`define CCI_ARM_WINDOW_MS          15000
`define CCI_SET_WINDOW_MS          10000
`define CCI_BLINK_HALF_MS          250
`define CCI_BLINK_HALVES           10

`endif

// [test/cci_can_master.sv]
// Bus controller model issuing request frames
`include "cci_map.vh"
module cci_can_master (
	// Clock
	input  wire        i_sys_clk,
	// Request frame
	output reg         o_req_valid,
	output reg  [28:0] o_req_id,
	output reg  [3:0]  o_req_len,
	output reg  [63:0] o_req_data
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		o_req_valid = 1'b0;
		o_req_id = 29'h0;
		o_req_len = 4'h0;
		o_req_data = 64'h0;
	end
	task send(input [7:0] dev, input [3:0] len, input [63:0] data);
		@(negedge i_sys_clk);
		o_req_valid = 1'b1;
		o_req_id = {`CCI_ID_REQ_BASE, dev};
		o_req_len = len;
		o_req_data = data;
		@(negedge i_sys_clk);
		// Stale id and data inverted so no old frame lingers
		o_req_valid = 1'b0;
		o_req_id = ~o_req_id;
		o_req_data = ~o_req_data;
	endtask
endmodule // cci_can_master

// [test/cci_checker_asserts.sv]
// Port-level assertions for the command interpreter
`include "cci_map.vh"
module cci_checker (
	// Clock and reset
	input wire        i_sys_clk,
	input wire        i_resetn,
	// Inputs
	input wire [2:0]  i_dip,
	input wire        i_remote_off,
	input wire        i_req_valid,
	input wire [28:0] i_req_id,
	input wire [3:0]  i_req_len,
	input wire [63:0] i_req_data,
	input wire [15:0] i_dc_voltage,
	// Outputs
	input wire        o_rsp_valid,
	input wire [28:0] o_rsp_id,
	input wire [3:0]  o_rsp_len,
	input wire [63:0] o_rsp_data,
	input wire        o_output_on,
	input wire        o_dc_to_ac,
	input wire [15:0] o_charge_v_set,
	input wire [15:0] o_setup_word,
	input wire        o_nv_store,
	input wire [5:0]  o_device_number,
	input wire        o_led_green,
	input wire        o_cfg_busy
);
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_resetn);
	wire hit = i_req_valid && i_req_id[28:8] == `CCI_ID_REQ_BASE
		&& (i_req_id[7:0] == {2'b00, o_device_number} || i_req_id[7:0] == `CCI_ID_BROADCAST);
	rsp_only_read_a: assert property (o_rsp_valid |-> $past(hit && i_req_len == 4'h2))
		else $error("response without read");
	rsp_id_base_a: assert property (o_rsp_valid |-> o_rsp_id == {`CCI_ID_RSP_BASE, 2'b00, o_device_number})
		else $error("response id wrong");
	rsp_code_echo_a: assert property (o_rsp_valid |-> o_rsp_data[15:0] == $past(i_req_data[15:0]))
		else $error("code not echoed");
	dc_volt_read_a: assert property (hit && i_req_len == 4'h2 && i_req_data[15:0] == 16'h0060
		|=> o_rsp_valid && o_rsp_len == 4'h4 && o_rsp_data[31:16] == $past(i_dc_voltage))
		else $error("dc voltage read wrong");
	dev_low_a: assert property (o_device_number[2:0] == i_dip)
		else $error("device number low bits wrong");
	dir_write_a: assert property (hit && i_req_len == 4'h3 && i_req_data[15:0] == 16'h0100
		|=> o_dc_to_ac == ($past(i_req_data[23:16]) == 8'h01))
		else $error("direction not applied");
	charge_v_write_a: assert property (hit && i_req_len == 4'h4 && i_req_data[15:0] == 16'h0020
		|=> o_charge_v_set == $past(i_req_data[31:16]))
		else $error("charge voltage not stored");
	nv_store_gate_a: assert property (o_nv_store |-> $past(o_setup_word[1:0]) == 2'b10)
		else $error("store pulse not allowed");
	on_not_inhibited_a: assert property (o_output_on |-> !i_remote_off)
		else $error("output on while inhibited");
	led_off_done_a: assert property (!o_cfg_busy |-> !o_led_green)
		else $error("indicator lit after setup");
	cover property (o_rsp_valid);
	cover property (o_nv_store);
	cover property ($fell(o_cfg_busy) && o_device_number[5:3] != 3'b000);
endmodule // cci_checker

bind cci_command_interpreter cci_checker u_chk (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_dip(i_dip),
	.i_remote_off(i_remote_off), .i_req_valid(i_req_valid), .i_req_id(i_req_id), .i_req_len(i_req_len),
	.i_req_data(i_req_data), .i_dc_voltage(i_dc_voltage), .o_rsp_valid(o_rsp_valid), .o_rsp_id(o_rsp_id),
	.o_rsp_len(o_rsp_len), .o_rsp_data(o_rsp_data), .o_output_on(o_output_on), .o_dc_to_ac(o_dc_to_ac),
	.o_charge_v_set(o_charge_v_set), .o_setup_word(o_setup_word), .o_nv_store(o_nv_store),
	.o_device_number(o_device_number), .o_led_green(o_led_green), .o_cfg_busy(o_cfg_busy));

// [test/tb_cci_command_interpreter.sv]
// Self-checking bench for the command interpreter
`include "cci_map.vh"
module tb_cci_command_interpreter;
	timeunit 1ns;
	timeprecision 1ns;
	localparam [143:0] CODES = {16'h00C0, 16'h00C1, 16'h0071, 16'h0070, 16'h0062, 16'h0061, 16'h0060,
		16'h0050, 16'h0040};
	localparam [63:0] SETS = {16'h0130, 16'h0120, 16'h0030, 16'h0020};
	// Arbitrary identity text, low word first
	localparam [239:0] IDS = {48'hFE01FFFFFFFF, 48'h5A5958575655, 48'h545352515049,
		48'h484746454443, 48'h424140393837};
	reg         clk, rstn, roff, pl;
	reg  [2:0]  dip;
	wire        qv, rv, on, d2a, nv, busy, led;
	wire [28:0] qid, rid;
	wire [3:0]  qlen, rlen;
	wire [63:0] qdat, rdat;
	wire [15:0] cv, ci, dv, di, sw, tw;
	wire [5:0]  num;
	reg  [15:0] meas [0:8];
	reg  [7:0]  rq;
	reg  [5:0]  en;
	integer     n_fail, checked, k, m;
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	cci_can_master u_can (.i_sys_clk(clk), .o_req_valid(qv), .o_req_id(qid), .o_req_len(qlen), .o_req_data(qdat));
	// Short counts keep the setup sequence within a few hundred cycles
	cci_command_interpreter #(.MAKER_LOW(IDS[47:0]), .MAKER_HIGH(IDS[95:48]), .MODEL_LOW(IDS[143:96]),
		.MODEL_HIGH(IDS[191:144]), .FW_REVS(IDS[239:192]),
		.ARM_CYCLES(200), .SET_CYCLES(100), .BLINK_CYCLES(4)) u_dut (
		.i_sys_clk(clk), .i_resetn(rstn), .i_dip(dip), .i_remote_off(roff),
		.i_req_valid(qv), .i_req_id(qid), .i_req_len(qlen), .i_req_data(qdat),
		.o_rsp_valid(rv), .o_rsp_id(rid), .o_rsp_len(rlen), .o_rsp_data(rdat),
		.i_fault_summary(meas[0]), .i_ac_voltage(meas[1]), .i_dc_voltage(meas[2]), .i_dc_current(meas[3]),
		.i_temperature(meas[4]), .i_fan1_speed(meas[5]), .i_fan2_speed(meas[6]), .i_system_state(meas[7]),
		.o_output_on(on), .o_dc_to_ac(d2a), .o_charge_v_set(cv), .o_charge_i_set(ci), .o_discharge_v_set(dv),
		.o_discharge_i_set(di), .o_setup_word(sw), .o_two_way_setup(tw), .o_nv_store(nv),
		.o_device_number(num), .o_led_green(led), .o_cfg_busy(busy));
	task final_report;
		if (n_fail == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task chk(input string name, input [63:0] exp, input [63:0] got);
		checked = checked + 1;
		if (got !== exp) begin
			n_fail = n_fail + 1;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask
	task rd(input [15:0] code, input [47:0] val, input integer n);
		reg [63:0] mask;
		mask = (64'h1 << (16 + 8 * n)) - 64'h1;
		// Response stands only until the next edge
		u_can.send(rq, 4'h2, {48'h0, code});
		chk("rsp_valid", 1, rv);
		chk("rsp_len", 2 + n, rlen);
		chk("rsp_id", {`CCI_ID_RSP_BASE, 2'b00, en}, rid);
		chk("rsp_data", {val, code} & mask, rdat & mask);
	endtask
	task quiet(input [7:0] dev, input [3:0] len, input [63:0] data);
		u_can.send(dev, len, data);
		chk("no_rsp", 0, rv);
	endtask
	task wr(input [15:0] code, input [47:0] val, input integer n);
		quiet(rq, 4'(2 + n), {val, code});
	endtask
	task do_reset(input [2:0] d, input r);
		rstn = 1'b0;
		dip = d;
		roff = r;
		repeat (4) @(negedge clk);
		rstn = 1'b1;
		repeat (4) @(negedge clk);
	endtask
	initial begin
		n_fail = 0;
		checked = 0;
		rq = 8'h05;
		en = 6'd5;
		for (k = 0; k < 8; k = k + 1)
			meas[k] = 16'h1111 * (k + 1);
		meas[8] = `CCI_SCALE_CODES_RESET;
		do_reset(3'b101, 1'b0);
		chk("dev_num", 6'd5, num);
		for (k = 0; k < 9; k = k + 1)
			rd(CODES[16*k +: 16], meas[k], 2);
		for (k = 0; k < 4; k = k + 1) begin
			wr(SETS[16*k +: 16], 16'h0960 + k, 2);
			rd(SETS[16*k +: 16], 16'h0960 + k, 2);
		end
		chk("discharge_i", 16'h0963, di);
		chk("charge_v", 16'h0960, cv);
		chk("charge_i", 16'h0961, ci);
		chk("discharge_v", 16'h0962, dv);
		wr(16'h00C2, 16'h0002, 2);
		chk("setup_word", 16'h0002, sw);
		wr(16'h0020, 16'h0A00, 2);
		chk("nv_store", 1, nv);
		wr(16'h00C2, 16'h0003, 2);
		wr(16'h0030, 16'h0B00, 2);
		chk("nv_store", 0, nv);
		for (k = 1; k >= 0; k = k - 1) begin
			wr(16'h0000, k, 1);
			chk("output_on", k, on);
			wr(16'h0100, k, 1);
			chk("dc_to_ac", k, d2a);
			rd(16'h0100, k, 1);
		end
		wr(16'h0087, 48'h313233343536, 6);
		rd(16'h0087, 48'h313233343536, 6);
		wr(16'h0085, 24'h414243, 3);
		rd(16'h0085, 24'h414243, 3);
		wr(16'h0086, 48'h393837363534, 6);
		rd(16'h0086, 48'h393837363534, 6);
		wr(16'h0088, 48'h303030303031, 6);
		rd(16'h0088, 48'h303030303031, 6);
		wr(16'h0140, 16'h0C3A, 2);
		chk("two_way_setup", 16'h0C3A, tw);
		rd(16'h0140, 16'h0C3A, 2);
		wr(16'h0080, 48'h0, 6);
		for (k = 0; k < 5; k = k + 1)
			rd(16'h0080 + 16'(k), IDS[48*k +: 48], 6);
		wr(16'h0060, 16'h1234, 2);
		wr(16'h00C0, 16'h0000, 2);
		rd(16'h00C0, `CCI_SCALE_CODES_RESET, 2);
		quiet(rq, 4'h2, 64'h0055);
		quiet(8'h06, 4'h4, 64'h11110020);
		rd(16'h0020, 16'h0A00, 2);
		rq = `CCI_ID_BROADCAST;
		rd(16'h0060, meas[2], 2);
		do_reset(3'b111, 1'b1);
		chk("cfg_busy", 1, busy);
		chk("output_on", 0, on);
		dip = 3'b011;
		repeat (3) @(negedge clk);
		dip = 3'b110;
		m = 0;
		pl = 1'b0;
		for (k = 0; k < 1000 && busy === 1'b1; k = k + 1) begin
			@(negedge clk);
			m = m + (led === 1'b1 && pl === 1'b0);
			pl = led;
		end
		if (busy !== 1'b0) begin
			n_fail = n_fail + 1;
			final_report;
		end
		chk("blinks", 10, m);
		dip = 3'b001;
		en = 6'h31;
		@(negedge clk);
		chk("dev_num", 6'h31, num);
		rq = 8'h31;
		wr(16'h0000, 1, 1);
		chk("output_on", 0, on);
		roff = 1'b0;
		@(negedge clk);
		chk("output_on", 1, on);
		rd(16'h0050, meas[1], 2);
		final_report;
	end
endmodule // tb_cci_command_interpreter
